/* File: rtl/smisr_pkg.sv */
// Package of constants and carrier types for the SMI second-level status mirror bank.
package smisr_pkg;

  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SMISR_IDX_PINS_GAME = 8'h84;
  localparam logic [7:0] SMISR_IDX_IDLE = 8'h85;
  localparam logic [7:0] SMISR_IDX_TRAPS = 8'h86;
  localparam logic [7:0] SMISR_IDX_MISC = 8'h87;
  localparam logic [7:0] SMISR_IDX_PINS_GAME_COR = 8'hF4;
  localparam logic [7:0] SMISR_IDX_IDLE_COR = 8'hF5;
  localparam logic [7:0] SMISR_IDX_TRAPS_COR = 8'hF6;
  localparam logic [7:0] SMISR_IDX_MISC_COR = 8'hF7;

  // ---------------------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SMISR_RESET = 8'h00;
  localparam logic [7:0] SMISR_PINS_GAME_VALID = 8'h1F;
  localparam logic [7:0] SMISR_TRAPS_VALID = 8'hBF;
  localparam int SMISR_GAME_BIT = 4;
  localparam int SMISR_LID_POS_BIT = 4;
  localparam int SMISR_LID_SMI_BIT = 3;
  localparam int SMISR_CODEC_BIT = 2;
  localparam int SMISR_TRAP_SEC_IDLE_BIT = 4;
  localparam int SMISR_NUM_PINS = 8;
  localparam int SMISR_LID_PIN = 6;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] idle_expire;
    logic [7:0] idle_enable;
    logic [7:0] trap_hit;
    logic [7:0] trap_enable;
    logic sec_idle_expire;
    logic sec_idle_enable;
    logic game_read;
    logic game_write;
    logic game_read_enable;
    logic game_write_enable;
    logic codec_sdata_in_enable;
  } smisr_event_t;

  typedef struct packed {
    logic [7:0] pin_is_gpio;
    logic [7:0] pin_is_input;
    logic [7:0] pin_smi_enable;
    logic lid_switch_select;
  } smisr_pin_cfg_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [7:0] index;
    logic [7:0] wdata;
  } smisr_cfg_req_t;

endpackage : smisr_pkg

/* File: rtl/smisr_pin_sync.sv */
// Two-flop synchroniser and transition detector for the general-purpose pins.
`timescale 1ns/1ps
module smisr_pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pins and results
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] pin_edge,
  output logic [WIDTH-1:0] pin_rise
);
  import smisr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } smisr_sync_state_t;

  smisr_sync_state_t state;
  smisr_sync_state_t next_state;

  initial begin
    if (WIDTH < 1) begin
      $error("smisr_pin_sync needs at least one pin");
    end
  end

  always_comb begin
    next_state = state;
    next_state.meta = pin_async;
    next_state.sync = state.meta;
    next_state.last = state.sync;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // The history stage starts at zero, so a pin held high through reset shows one rising edge.
  assign pin_level = state.sync;
  assign pin_edge = state.sync ^ state.last;
  assign pin_rise = state.sync & ~state.last;

endmodule : smisr_pin_sync

/* File: rtl/smisr_status_mirror.sv */
// Second-level SMI status mirror registers with clear-on-read twins.
//
// What this block does
// R1 - Mirror one bit 4 flags game-port access SMI; bits 7 to 5 read zero.
// R2 - Game-port reads and writes have separate enables, sharing one status bit.
// R3 - Mirror one bits 3 to 0 flag enabled transitions on pins 7,5,4,3.
// R4 - A pin counts only when selected as GPIO, input, and SMI enabled.
// R5 - Mirror reads keep status; twin reads at paired indices clear it.
// R6 - Any captured second-level cause shows in the top-level summary bit.
// R7 - Mirror two holds enabled idle-timer expiries, video bit 7 to hard disk bit 0.
// R8 - Mirror three flags enabled device traps; bit 6 reads zero.
// R9 - Mirror three bit 4 flags enabled secondary hard disk idle expiry.
// R10 - Mirror four bits 7 to 5 flag enabled transitions on pins 2,1,0.
// R11 - Mirror four bit 4 follows the lid pin level when lid switch selected.
// R12 - Mirror four bit 3 flags lid pin transition, only as input and lid switch.
// R13 - Mirror four bit 2 flags enabled rising edge on codec data-in.
// R14 - Idle, trap and misc mirrors are read-only and reset to zero.
// R15 - Mirror four has a clear-on-read twin; mirror read leaves status intact.
// R16 - Reserved bits read zero; writes to these registers have no effect.
`timescale 1ns/1ps
module smisr_status_mirror (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Configuration space access
  input wire smisr_pkg::smisr_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_hit,
  // Event sources on this clock
  input wire smisr_pkg::smisr_event_t events,
  input wire smisr_pkg::smisr_pin_cfg_t pin_cfg,
  // Pins from outside
  input wire logic [7:0] general_purpose_pin_async,
  input wire logic codec_sdata_in_async,
  // Summary
  output logic top_level_smi_status
);
  import smisr_pkg::*;

  typedef struct packed {
    logic [7:0] pins_game;
    logic [7:0] idle;
    logic [7:0] traps;
    logic [7:0] misc;
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
    logic top;
  } smisr_state_t;

  smisr_state_t state;
  smisr_state_t next_state;
  logic [8:0] pin_level;
  logic [8:0] pin_edge;
  logic [8:0] pin_rise;
  logic [7:0] pin_ok;
  logic [7:0] set_pins_game;
  logic [7:0] set_idle;
  logic [7:0] set_traps;
  logic [7:0] set_misc;
  logic [7:0] clr_pins_game;
  logic [7:0] clr_idle;
  logic [7:0] clr_traps;
  logic [7:0] clr_misc;
  logic lid_pos;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] smisr_update(input logic [7:0] cur, input logic [7:0] set,
                                              input logic [7:0] clr);
    // A new event wins over a clear in the same cycle so no SMI cause is lost.
    smisr_update = (cur & ~clr) | set;
  endfunction : smisr_update

  function automatic logic [7:0] smisr_clear_mask(input smisr_cfg_req_t req,
                                                  input logic [7:0] twin);
    smisr_clear_mask = (req.rd_en && req.index == twin) ? 8'hFF : 8'h00;
  endfunction : smisr_clear_mask

  function automatic logic smisr_is_mapped(input logic [7:0] idx);
    smisr_is_mapped = idx inside {SMISR_IDX_PINS_GAME, SMISR_IDX_IDLE, SMISR_IDX_TRAPS,
                                  SMISR_IDX_MISC, SMISR_IDX_PINS_GAME_COR, SMISR_IDX_IDLE_COR,
                                  SMISR_IDX_TRAPS_COR, SMISR_IDX_MISC_COR};
  endfunction : smisr_is_mapped

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  smisr_pin_sync #(
    .WIDTH(9)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin_async({codec_sdata_in_async, general_purpose_pin_async}),
    .pin_level(pin_level),
    .pin_edge(pin_edge),
    .pin_rise(pin_rise)
  );

  // ---------------------------------------------------------------------------
  // Event gathering
  // ---------------------------------------------------------------------------
  always_comb begin
    pin_ok = pin_cfg.pin_is_gpio & pin_cfg.pin_is_input & pin_cfg.pin_smi_enable &
             pin_edge[7:0]; // R4
    lid_pos = pin_cfg.lid_switch_select & pin_level[SMISR_LID_PIN];

    set_pins_game = 8'h00;
    set_pins_game[SMISR_GAME_BIT] = (events.game_read & events.game_read_enable) |
                                    (events.game_write & events.game_write_enable); // R1 R2
    set_pins_game[3:0] = {pin_ok[7], pin_ok[5], pin_ok[4], pin_ok[3]}; // R3

    set_idle = events.idle_expire & events.idle_enable; // R7

    set_traps = events.trap_hit & events.trap_enable & SMISR_TRAPS_VALID; // R8
    set_traps[SMISR_TRAP_SEC_IDLE_BIT] = events.sec_idle_expire & events.sec_idle_enable; // R9

    set_misc = 8'h00;
    set_misc[7:5] = {pin_ok[2], pin_ok[1], pin_ok[0]}; // R10
    set_misc[SMISR_LID_SMI_BIT] = pin_edge[SMISR_LID_PIN] & pin_cfg.pin_is_input[SMISR_LID_PIN] &
                                  pin_cfg.lid_switch_select; // R12
    set_misc[SMISR_CODEC_BIT] = pin_rise[8] & events.codec_sdata_in_enable; // R13

    clr_pins_game = smisr_clear_mask(cfg_req, SMISR_IDX_PINS_GAME_COR); // R5
    clr_idle = smisr_clear_mask(cfg_req, SMISR_IDX_IDLE_COR); // R5
    clr_traps = smisr_clear_mask(cfg_req, SMISR_IDX_TRAPS_COR); // R5
    clr_misc = smisr_clear_mask(cfg_req, SMISR_IDX_MISC_COR); // R15
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Writes are never decoded, so software alters these registers only by clearing them through twin reads.
    next_state.pins_game = smisr_update(state.pins_game, set_pins_game, clr_pins_game) &
                           SMISR_PINS_GAME_VALID; // R16
    next_state.idle = smisr_update(state.idle, set_idle, clr_idle);
    next_state.traps = smisr_update(state.traps, set_traps, clr_traps) & SMISR_TRAPS_VALID; // R16
    next_state.misc = smisr_update(state.misc, set_misc, clr_misc);
    // The lid position is a live level, not a sticky flag, so clears do not touch it.
    next_state.misc[SMISR_LID_POS_BIT] = lid_pos; // R11
    next_state.top = |{next_state.pins_game, next_state.idle, next_state.traps,
                       next_state.misc & ~(8'h01 << SMISR_LID_POS_BIT)}; // R6
    next_state.rvalid = cfg_req.rd_en;
    next_state.hit = 1'b0;
    next_state.rdata = 8'h00;
    if (cfg_req.rd_en) begin
      case (cfg_req.index)
        SMISR_IDX_PINS_GAME, SMISR_IDX_PINS_GAME_COR: begin
          next_state.rdata = state.pins_game; // R5
          next_state.hit = 1'b1;
        end
        SMISR_IDX_IDLE, SMISR_IDX_IDLE_COR: begin
          next_state.rdata = state.idle;
          next_state.hit = 1'b1;
        end
        SMISR_IDX_TRAPS, SMISR_IDX_TRAPS_COR: begin
          next_state.rdata = state.traps;
          next_state.hit = 1'b1;
        end
        SMISR_IDX_MISC, SMISR_IDX_MISC_COR: begin
          next_state.rdata = state.misc; // R15
          next_state.hit = 1'b1;
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0; // R14
    end else begin
      state <= next_state;
    end
  end

  assign cfg_rdata = state.rdata;
  assign cfg_rvalid = state.rvalid;
  assign cfg_hit = state.hit;
  assign top_level_smi_status = state.top;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_mirror_read(logic [7:0] idx);
    cfg_req.rd_en && cfg_req.index == idx;
  endsequence

  sequence s_unmapped_read;
    cfg_req.rd_en && !smisr_is_mapped(cfg_req.index);
  endsequence

  chk_game_status_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
    (events.game_read && events.game_read_enable) |=> state.pins_game[SMISR_GAME_BIT])
    else $error("game-port read did not set its status bit");

  chk_game_write_gated: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
    (events.game_write && !events.game_write_enable && !events.game_read &&
     !state.pins_game[SMISR_GAME_BIT]) |=> !state.pins_game[SMISR_GAME_BIT])
    else $error("disabled game-port write set the status bit");

  chk_pin_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
    (!pin_cfg.pin_is_input[4] && !state.pins_game[1]) |=> !state.pins_game[1])
    else $error("output pin transition set its status bit");

  chk_mirror_keeps: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
    (s_mirror_read(SMISR_IDX_IDLE) ##0 state.idle != 8'h00) |=> (state.idle & $past(state.idle))
    == $past(state.idle))
    else $error("mirror read cleared status");

  chk_twin_clears: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    (s_mirror_read(SMISR_IDX_MISC_COR) ##0 set_misc == 8'h00) |=>
    (state.misc & 8'hEF) == 8'h00)
    else $error("twin read did not clear status");

  chk_read_data: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
    s_mirror_read(SMISR_IDX_TRAPS) |=> cfg_rvalid && cfg_hit && cfg_rdata == $past(state.traps))
    else $error("trap mirror read returned wrong data");

  chk_idle_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    (events.idle_expire[7] && events.idle_enable[7]) |=> state.idle[7])
    else $error("video idle expiry not captured");

  chk_trap_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
    !state.traps[6] && state.pins_game[7:5] == 3'h0)
    else $error("reserved status bit set");

  chk_top_summary: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    (state.idle != 8'h00) |-> top_level_smi_status)
    else $error("top-level summary missing a cause");

  chk_lid_level: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
    (pin_cfg.lid_switch_select ##1 pin_cfg.lid_switch_select) |->
    state.misc[SMISR_LID_POS_BIT] == $past(pin_level[SMISR_LID_PIN]))
    else $error("lid position does not follow the pin");

  chk_codec_edge: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
    (pin_rise[8] && events.codec_sdata_in_enable) |=> state.misc[SMISR_CODEC_BIT])
    else $error("codec rising edge not captured");

  chk_game_read_gated: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
    (events.game_read && !events.game_read_enable && !events.game_write &&
     !state.pins_game[SMISR_GAME_BIT]) |=> !state.pins_game[SMISR_GAME_BIT])
    else $error("disabled game-port read set the status bit");

  chk_pin_status_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
    pin_ok[7] |=> state.pins_game[3])
    else $error("enabled pin seven transition not captured");

  chk_pin_gpio_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
    (pin_edge[5] && !pin_cfg.pin_is_gpio[5] && !state.pins_game[2]) |=> !state.pins_game[2])
    else $error("pin not selected for general use set its status bit");

  chk_pin_enable_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
    (pin_edge[3] && !pin_cfg.pin_smi_enable[3] && !state.pins_game[0]) |=> !state.pins_game[0])
    else $error("pin without SMI enable set its status bit");

  chk_idle_gated: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    (events.idle_expire[0] && !events.idle_enable[0] && !state.idle[0]) |=> !state.idle[0])
    else $error("disabled idle expiry set its status bit");

  chk_trap_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    (events.trap_hit[7] && events.trap_enable[7]) |=> state.traps[7])
    else $error("video trap not captured");

  chk_trap_gated: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    (events.trap_hit[0] && !events.trap_enable[0] && !state.traps[0]) |=> !state.traps[0])
    else $error("disabled trap set its status bit");

  chk_sec_idle_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
    (events.sec_idle_expire && events.sec_idle_enable) |=> state.traps[SMISR_TRAP_SEC_IDLE_BIT])
    else $error("secondary disk idle expiry not captured");

  chk_misc_pin_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
    pin_ok[0] |=> state.misc[5])
    else $error("enabled pin zero transition not captured");

  chk_lid_edge_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
    (pin_edge[SMISR_LID_PIN] && pin_cfg.pin_is_input[SMISR_LID_PIN] &&
     pin_cfg.lid_switch_select) |=> state.misc[SMISR_LID_SMI_BIT])
    else $error("lid switch transition not captured");

  chk_lid_edge_gated: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
    (pin_edge[SMISR_LID_PIN] && !pin_cfg.pin_is_input[SMISR_LID_PIN] &&
     !state.misc[SMISR_LID_SMI_BIT]) |=> !state.misc[SMISR_LID_SMI_BIT])
    else $error("lid transition on an output pin set its status bit");

  chk_codec_gated: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
    (pin_rise[8] && !events.codec_sdata_in_enable && !state.misc[SMISR_CODEC_BIT]) |=>
    !state.misc[SMISR_CODEC_BIT])
    else $error("disabled codec edge set its status bit");

  chk_reset_zero: assert property (@(posedge clk_sys) // R14
    !rst_b |=> state.pins_game == 8'h00 && state.idle == 8'h00 && state.traps == 8'h00 &&
    state.misc == 8'h00 && !cfg_rvalid && !top_level_smi_status)
    else $error("status not zero during reset");

  chk_misc_mirror_keeps: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    s_mirror_read(SMISR_IDX_MISC) |=>
    (state.misc & $past(state.misc) & 8'hEF) == ($past(state.misc) & 8'hEF))
    else $error("misc mirror read cleared status");

  chk_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
    (cfg_req.wr_en && !cfg_req.rd_en && set_idle == 8'h00 && set_traps == 8'h00) |=>
    state.idle == $past(state.idle) && state.traps == $past(state.traps))
    else $error("write altered a read-only register");

  chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
    s_unmapped_read |=> cfg_rvalid && !cfg_hit && cfg_rdata == 8'h00)
    else $error("unmapped read did not answer zero without hit");

  chk_top_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    (state.pins_game == 8'h00 && state.idle == 8'h00 && state.traps == 8'h00 &&
     (state.misc & 8'hEF) == 8'h00) |-> !top_level_smi_status)
    else $error("top-level summary set with no cause");

endmodule : smisr_status_mirror

/* File: verif/smisr_status_mirror_bench.sv */
// Self-checking bench for the SMI second-level status mirror bank.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module smisr_status_mirror_bench;
  import smisr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  smisr_cfg_req_t cfg_req = '0;
  smisr_event_t events = '0;
  smisr_pin_cfg_t pin_cfg = '0;
  logic [7:0] general_purpose_pin_async = 8'h00;
  logic codec_sdata_in_async = 1'b0;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic cfg_hit;
  logic top_level_smi_status;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  smisr_status_mirror u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .cfg_hit(cfg_hit), .events(events), .pin_cfg(pin_cfg),
    .general_purpose_pin_async(general_purpose_pin_async),
    .codec_sdata_in_async(codec_sdata_in_async), .top_level_smi_status(top_level_smi_status)
  );

  // ---------------------------------------------------------------------------
  // Clock, watchdog and verdict
  // ---------------------------------------------------------------------------
  always #2 clk_sys = ~clk_sys;

  // The whole run needs well under a thousand cycles; the ceiling leaves margin.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------------
  // Access helpers
  // ---------------------------------------------------------------------------
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d, output logic h);
    @(negedge clk_sys);
    cfg_req.rd_en = 1'b1;
    cfg_req.index = idx;
    @(negedge clk_sys);
    // The answer stands for one cycle only, so it is taken before the strobe drops.
    `CHK("rvalid", 1'b1, cfg_rvalid)
    d = cfg_rdata;
    h = cfg_hit;
    cfg_req.rd_en = 1'b0;
  endtask : rd_reg

  task automatic chk_reg(input logic [7:0] idx, input logic [7:0] ex);
    logic [7:0] d;
    logic h;
    rd_reg(idx, d, h);
    `CHK($sformatf("hit %h", idx), 1'b1, h)
    `CHK($sformatf("reg %h", idx), ex, d)
  endtask : chk_reg

  task automatic pulse(input smisr_event_t ev);
    @(negedge clk_sys);
    events = ev;
    @(negedge clk_sys);
    events = '0;
  endtask : pulse

  // Pins pass a two-flop synchroniser, so a change needs three edges to land.
  task automatic pins(input logic [7:0] p);
    @(negedge clk_sys);
    general_purpose_pin_async = p;
    repeat (5) @(negedge clk_sys);
  endtask : pins

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_write();
    logic [7:0] d;
    logic h;
    for (int i = 0; i < 4; i++) begin
      chk_reg(8'h84 + 8'(i), 8'h00);
      chk_reg(8'hF4 + 8'(i), 8'h00);
      @(negedge clk_sys);
      cfg_req.wr_en = 1'b1;
      cfg_req.index = 8'h84 + 8'(i);
      cfg_req.wdata = 8'hFF;
      @(negedge clk_sys);
      cfg_req.wr_en = 1'b0;
      chk_reg(8'h84 + 8'(i), 8'h00);
    end
    rd_reg(8'h88, d, h);
    `CHK("unmapped hit", 1'b0, h)
    `CHK("unmapped data", 8'h00, d)
  endtask : t_reset_write

  task automatic t_idle();
    smisr_event_t ev;
    ev = '0;
    ev.idle_expire = 8'hFF;
    ev.idle_enable = 8'h5A;
    pulse(ev);
    @(negedge clk_sys);
    `CHK("top", 1'b1, top_level_smi_status)
    chk_reg(SMISR_IDX_IDLE, 8'h5A);
    chk_reg(SMISR_IDX_IDLE, 8'h5A);
    chk_reg(SMISR_IDX_IDLE_COR, 8'h5A);
    chk_reg(SMISR_IDX_IDLE, 8'h00);
    `CHK("top", 1'b0, top_level_smi_status)
  endtask : t_idle

  task automatic t_traps();
    smisr_event_t ev;
    ev = '0;
    ev.trap_hit = 8'hE5;
    ev.sec_idle_expire = 1'b1;
    pulse(ev);
    chk_reg(SMISR_IDX_TRAPS, 8'h00);
    ev.trap_enable = 8'hFF;
    ev.sec_idle_enable = 1'b1;
    pulse(ev);
    chk_reg(SMISR_IDX_TRAPS, 8'hB5);
    chk_reg(SMISR_IDX_TRAPS_COR, 8'hB5);
    chk_reg(SMISR_IDX_TRAPS, 8'h00);
  endtask : t_traps

  task automatic t_game();
    smisr_event_t ev;
    ev = '0;
    ev.game_read = 1'b1;
    ev.game_write = 1'b1;
    pulse(ev);
    chk_reg(SMISR_IDX_PINS_GAME, 8'h00);
    ev = '0;
    ev.game_read = 1'b1;
    ev.game_write_enable = 1'b1;
    pulse(ev);
    ev = '0;
    ev.game_write = 1'b1;
    ev.game_read_enable = 1'b1;
    pulse(ev);
    chk_reg(SMISR_IDX_PINS_GAME, 8'h00);
    ev.game_read = 1'b0;
    ev.game_write_enable = 1'b1;
    pulse(ev);
    chk_reg(SMISR_IDX_PINS_GAME_COR, 8'h10);
    ev = '0;
    ev.game_read = 1'b1;
    ev.game_read_enable = 1'b1;
    pulse(ev);
    chk_reg(SMISR_IDX_PINS_GAME_COR, 8'h10);
    chk_reg(SMISR_IDX_PINS_GAME, 8'h00);
  endtask : t_game

  task automatic t_pins();
    pin_cfg.pin_is_gpio = 8'hFF;
    pin_cfg.pin_is_input = 8'hFF;
    pin_cfg.pin_smi_enable = 8'hFF;
    pins(8'h80);
    chk_reg(SMISR_IDX_PINS_GAME_COR, 8'h08);
    pins(8'hBF);
    chk_reg(SMISR_IDX_PINS_GAME_COR, 8'h07);
    chk_reg(SMISR_IDX_MISC_COR, 8'hE0);
    pin_cfg.pin_smi_enable[3] = 1'b0;
    pin_cfg.pin_is_input[4] = 1'b0;
    pin_cfg.pin_is_gpio[5] = 1'b0;
    pins(8'h84);
    chk_reg(SMISR_IDX_PINS_GAME, 8'h00);
    chk_reg(SMISR_IDX_MISC_COR, 8'h60);
  endtask : t_pins

  task automatic t_lid();
    pin_cfg.lid_switch_select = 1'b1;
    pins(8'hC4);
    chk_reg(SMISR_IDX_MISC, 8'h18);
    chk_reg(SMISR_IDX_MISC_COR, 8'h18);
    chk_reg(SMISR_IDX_MISC, 8'h10);
    pins(8'h84);
    chk_reg(SMISR_IDX_MISC_COR, 8'h08);
    pin_cfg.pin_is_input[6] = 1'b0;
    pins(8'hC4);
    chk_reg(SMISR_IDX_MISC, 8'h10);
    pin_cfg.lid_switch_select = 1'b0;
    pin_cfg.pin_is_input[6] = 1'b1;
    pins(8'h84);
    chk_reg(SMISR_IDX_MISC, 8'h00);
  endtask : t_lid

  task automatic t_codec();
    events.codec_sdata_in_enable = 1'b1;
    codec_sdata_in_async = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk_reg(SMISR_IDX_MISC_COR, 8'h04);
    codec_sdata_in_async = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk_reg(SMISR_IDX_MISC, 8'h00);
    events.codec_sdata_in_enable = 1'b0;
    codec_sdata_in_async = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk_reg(SMISR_IDX_MISC, 8'h00);
  endtask : t_codec

  initial begin
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset_write();
    t_idle();
    t_traps();
    t_game();
    t_pins();
    t_lid();
    t_codec();
    test_done();
  end
endmodule : smisr_status_mirror_bench
